// ===== src/ldft_cfg.svh
`ifndef LDFT_CFG_SVH
`define LDFT_CFG_SVH

// ==========================================================
// register map
`define LDFT_ADDR_W 5
`define LDFT_ADDR_PAGE_SELECTOR 5'h13
`define LDFT_ADDR_FREQ 5'h15
`define LDFT_ADDR_TDR 5'h16
`define LDFT_PAGE_DIAG 3'h2
`define LDFT_PAGE_RST 3'h0

// ==========================================================
// field positions
`define LDFT_PAGE_MSB 2
`define LDFT_FREQ_TRIG_BIT 15
`define LDFT_FREQ_SEL_BIT 8
`define LDFT_FREQ_RES_MSB 7
`define LDFT_TDR_EN_BIT 15
`define LDFT_TDR_FAST_BIT 14
`define LDFT_TDR_PAIR_BIT 13

// ==========================================================
// reset values
`define LDFT_RESULT_RST 8'h00
`define LDFT_SEL_RST 1'b0
`define LDFT_TDR_EN_RST 1'b0
`define LDFT_TDR_FAST_RST 1'b0
`define LDFT_TDR_PAIR_RST 1'b0

// ==========================================================
// timing
`define LDFT_CLK_NS 10
`define LDFT_FAST_STEP_NS 8
`define LDFT_PRE_NS 50
`define LDFT_FULL_NS 100
`define LDFT_PRE_CYC ((`LDFT_PRE_NS + `LDFT_CLK_NS - 1) / `LDFT_CLK_NS)
`define LDFT_FULL_CYC ((`LDFT_FULL_NS + `LDFT_CLK_NS - 1) / `LDFT_CLK_NS)

`endif

// ===== src/ldft_freq_sampler.sv
`timescale 1ns/1ps
`include "ldft_cfg.svh"

module ldft_freq_sampler
  import ldft_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // software side
  input wire logic trigger,
  input wire logic trigger_sel,
  output logic busy,
  output logic [7:0] result,
  // signal processor side
  output logic dsp_req,
  output logic dsp_sel,
  input wire logic dsp_ack,
  input wire logic [7:0] dsp_value
);

  ldft_samp_type s_q;
  ldft_samp_type s_d;

  // ==========================================================
  // request, wait, load
  always_comb begin
    s_d = s_q;
    case (s_q.state)
      LDFT_S_IDLE: begin
        // a trigger while a poll is open is dropped
        if (trigger) begin
          s_d.sel = trigger_sel;
          s_d.state = LDFT_S_WAIT;
        end
      end
      LDFT_S_WAIT: begin
        // old byte stays until the whole new one arrives
        if (dsp_ack) begin
          s_d.result = dsp_value;
          s_d.state = LDFT_S_IDLE;
        end
      end
      default: s_d.state = LDFT_S_IDLE;
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q.state <= LDFT_S_IDLE;
      s_q.sel <= `LDFT_SEL_RST;
      s_q.result <= `LDFT_RESULT_RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // request held until the processor answers
  assign dsp_req = (s_q.state == LDFT_S_WAIT);
  assign busy = dsp_req;
  assign dsp_sel = s_q.sel;
  assign result = s_q.result;

endmodule

// ===== src/ldft_pkg.sv
package ldft_pkg;

  // ==========================================================
  // sampler states
  typedef enum logic [1:0] {
    LDFT_S_IDLE = 2'b01,
    LDFT_S_WAIT = 2'b10
  } ldft_samp_state_type;

  // ==========================================================
  // module state records
  typedef struct packed {
    ldft_samp_state_type state;
    logic sel;
    logic [7:0] result;
  } ldft_samp_type;

  typedef struct packed {
    logic active;
    logic neg;
    logic next_neg;
    logic full;
    logic [4:0] cnt;
  } ldft_pulse_type;

  typedef struct packed {
    logic [2:0] page;
    logic sel;
    logic tdr_en;
    logic fast;
    logic pair;
    logic [15:0] rdata;
  } ldft_regs_type;

endpackage

// ===== src/ldft_pulse_gen.sv
`timescale 1ns/1ps
`include "ldft_cfg.svh"

module ldft_pulse_gen
  import ldft_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // control
  input wire logic enable,
  input wire logic fast,
  input wire logic fire,
  input wire logic [2:0] width,
  // pulse drive
  output logic pulse_on,
  output logic pulse_neg,
  output logic pulse_full
);

  ldft_pulse_type p_q;
  ldft_pulse_type p_d;

  // 8 ns steps on a 10 ns clock, rounded up
  function automatic logic [4:0] fast_cycles(input logic [2:0] w);
    logic [6:0] ns;
    ns = 7'(w) * 7'(`LDFT_FAST_STEP_NS) + 7'(`LDFT_CLK_NS - 1);
    return 5'(ns / 7'(`LDFT_CLK_NS));
  endfunction

  // ==========================================================
  // launch and time one pulse
  always_comb begin
    p_d = p_q;
    if (p_q.active) begin
      p_d.cnt = p_q.cnt - 5'h01;
      if (p_q.cnt == 5'h01) begin
        p_d.active = 1'b0;
      end
    end else if (fire && enable && width != 3'h0) begin
      p_d.active = 1'b1;
      if (fast) begin
        p_d.cnt = fast_cycles(width);
        p_d.full = 1'b0;
        p_d.neg = p_q.next_neg;
        p_d.next_neg = ~p_q.next_neg;
      end else begin
        // link pulses are always positive
        p_d.neg = 1'b0;
        p_d.full = (width >= 3'h2);
        p_d.cnt = p_d.full ? 5'(`LDFT_FULL_CYC) : 5'(`LDFT_PRE_CYC);
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      p_q <= '0;
    end else if (clk_en) begin
      p_q <= p_d;
    end
  end

  assign pulse_on = p_q.active;
  assign pulse_neg = p_q.neg;
  assign pulse_full = p_q.full;

endmodule

// ===== src/ldft_regs.sv
// Function
// - trigger with select low fetches long-term offset into result.
// - trigger with select high fetches frequency control value into result.
// - trigger bit always reads back as zero.
// - bits 14:9 of frequency register ignore writes, read zero.
// - select bit is read-write, resets to zero, picks control value.
// - result byte resets to zero, loads only processor answer after trigger.
// - result is signed two's complement, about five ppm per step.
// - test enable forces power-up state for pulse operation.
// - fast select uses 100 Mb transmitter, widths in 8 ns steps.
// - fast pulses alternate positive and negative.
// - default uses link pulse generator, 50 ns or 100 ns.
// - frequency register at 0x15 of diagnostics page, bits 15, 8, 7:0.
// - pair select zero sends on transmit pair, one on receive pair.
`timescale 1ns/1ps
`include "ldft_cfg.svh"

module ldft_regs
  import ldft_pkg::*;
(
  // clock, enable and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,

  // register port
  input wire logic [`LDFT_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,

  // receive signal processor
  output logic dsp_req,
  output logic dsp_sel,
  input wire logic dsp_ack,
  input wire logic [7:0] dsp_value,

  // cable test control
  output logic reflect_test_on,
  output logic powerup_force,
  output logic fast_transmitter_pulse_select,
  output logic tx_on_rx_pair,

  // cable test pulse launch
  input wire logic tdr_fire,
  input wire logic [2:0] tdr_width,
  output logic pulse_on,
  output logic pulse_neg,
  output logic pulse_full
);

  // ==========================================================
  // state

  ldft_regs_type r_q;
  ldft_regs_type r_d;

  logic diag_page;
  logic hit_page;
  logic hit_freq;
  logic hit_tdr;
  logic freq_trigger;
  logic samp_busy;
  logic [7:0] samp_result;

  // ==========================================================
  // address decode

  // page register answers on every page so software can
  // always get back to the diagnostics page
  assign diag_page = (r_q.page == `LDFT_PAGE_DIAG);

  assign hit_page = (reg_addr == `LDFT_ADDR_PAGE_SELECTOR);

  // page 2 registers only decode with the page selected
  assign hit_freq = diag_page && (reg_addr == `LDFT_ADDR_FREQ);

  assign hit_tdr = diag_page && (reg_addr == `LDFT_ADDR_TDR);

  // ==========================================================
  // sample trigger

  // a write of one fires the poll; nothing is stored;
  // a trigger during an open poll is not passed on
  assign freq_trigger = clk_en && reg_wr && hit_freq && !samp_busy
    && reg_wdata[`LDFT_FREQ_TRIG_BIT];

  // ==========================================================
  // register writes and read data

  always_comb begin
    r_d = r_q;

    // read data stands only for the cycle after the read
    r_d.rdata = 16'h0000;

    if (reg_wr) begin
      if (hit_page) begin
        r_d.page = reg_wdata[`LDFT_PAGE_MSB:0];
      end

      if (hit_freq) begin
        // bits 14:9 and 7:0 are not writable here
        r_d.sel = reg_wdata[`LDFT_FREQ_SEL_BIT];
      end

      if (hit_tdr) begin
        r_d.tdr_en = reg_wdata[`LDFT_TDR_EN_BIT];
        r_d.fast = reg_wdata[`LDFT_TDR_FAST_BIT];
        r_d.pair = reg_wdata[`LDFT_TDR_PAIR_BIT];
      end
    end

    if (reg_rd) begin
      if (hit_page) begin
        r_d.rdata[`LDFT_PAGE_MSB:0] = r_q.page;
      end

      if (hit_freq) begin
        // trigger and reserved bits stay zero
        r_d.rdata[`LDFT_FREQ_TRIG_BIT] = 1'b0;
        r_d.rdata[`LDFT_FREQ_SEL_BIT] = r_q.sel;
        r_d.rdata[`LDFT_FREQ_RES_MSB:0] = samp_result;
      end

      if (hit_tdr) begin
        r_d.rdata[`LDFT_TDR_EN_BIT] = r_q.tdr_en;
        r_d.rdata[`LDFT_TDR_FAST_BIT] = r_q.fast;
        r_d.rdata[`LDFT_TDR_PAIR_BIT] = r_q.pair;
      end

      // unmapped addresses read zero, as do 0x15 and 0x16 on other pages
    end
  end

  // ==========================================================
  // state register

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_q.page <= `LDFT_PAGE_RST;
      r_q.sel <= `LDFT_SEL_RST;
      r_q.tdr_en <= `LDFT_TDR_EN_RST;
      r_q.fast <= `LDFT_TDR_FAST_RST;
      r_q.pair <= `LDFT_TDR_PAIR_RST;
      r_q.rdata <= 16'h0000;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // frequency sampler

  // the select written with the trigger governs that poll,
  // so one write can both choose and fire
  ldft_freq_sampler u_sampler (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .trigger(freq_trigger),
    .trigger_sel(reg_wdata[`LDFT_FREQ_SEL_BIT]),
    .busy(samp_busy),
    .result(samp_result),
    .dsp_req(dsp_req),
    .dsp_sel(dsp_sel),
    .dsp_ack(dsp_ack),
    .dsp_value(dsp_value)
  );

  // ==========================================================
  // cable test pulse generator

  // the generator only fires while test mode is on
  ldft_pulse_gen u_pulse (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .enable(r_q.tdr_en),
    .fast(r_q.fast),
    .fire(tdr_fire),
    .width(tdr_width),
    .pulse_on(pulse_on),
    .pulse_neg(pulse_neg),
    .pulse_full(pulse_full)
  );

  // ==========================================================
  // outputs

  assign reg_rdata = r_q.rdata;

  assign reflect_test_on = r_q.tdr_en;

  // power-up override follows the enable directly
  assign powerup_force = r_q.tdr_en;

  assign fast_transmitter_pulse_select = r_q.fast;

  assign tx_on_rx_pair = r_q.pair;

endmodule

// ===== testbench/ldft_regs_assertions.sv
`timescale 1ns/1ps
module ldft_regs_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // processor and cable test
  input wire logic dsp_req,
  input wire logic dsp_sel,
  input wire logic dsp_ack,
  input wire logic reflect_test_on,
  input wire logic powerup_force,
  input wire logic fast_transmitter_pulse_select,
  input wire logic tdr_fire,
  input wire logic [2:0] tdr_width,
  input wire logic pulse_on,
  input wire logic pulse_full
);
  // ==========================================
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_trig_rd;
    $past(reg_rd && clk_en && reg_addr == 5'h15) |-> reg_rdata[15:9] == 7'h00;
  endproperty
  a_trig_rd: assert property (p_trig_rd)
    else $error("freq register top bits read high");
  property p_rd_idle;
    $past(clk_en && !reg_rd) |-> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
  property p_pwr;
    powerup_force == reflect_test_on;
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("power-up force differs from enable");
  // the request must not wobble until the processor answers
  property p_req_hold;
    dsp_req && !dsp_ack |=> dsp_req && $stable(dsp_sel);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("poll request dropped early");
  property p_ack_drop;
    dsp_req && dsp_ack && clk_en |=> !dsp_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("poll request stays after answer");
  property p_off;
    !reflect_test_on && !pulse_on |=> !pulse_on;
  endproperty
  a_off: assert property (p_off)
    else $error("pulse while test disabled");
  sequence s_fire1;
    tdr_fire && clk_en && reflect_test_on && tdr_width == 3'h1 && !pulse_on;
  endsequence
  property p_fast1;
    s_fire1 ##0 fast_transmitter_pulse_select |=> pulse_on ##1 !pulse_on;
  endproperty
  a_fast1: assert property (p_fast1)
    else $error("fast pulse of width one wrong length");
  property p_slow1;
    s_fire1 ##0 !fast_transmitter_pulse_select
      |=> (pulse_on && !pulse_full)[*5] ##1 !pulse_on;
  endproperty
  a_slow1: assert property (p_slow1)
    else $error("short link pulse wrong length");
  c_ack: cover property (dsp_req && dsp_ack);
  c_pulse: cover property ($rose(pulse_on));
  c_rd: cover property (reg_rd && reg_addr == 5'h15);
endmodule

// ===== testbench/ldft_regs_test.sv
`timescale 1ns/1ps
module ldft_regs_test;
  logic ref_clk = 0, arst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic dsp_ack = 0, tdr_fire = 0;
  logic [4:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, d;
  logic [7:0] dsp_value = 0, res_m, v;
  logic [2:0] tdr_width = 0;
  logic dsp_req, dsp_sel, reflect_test_on, powerup_force, neg_m;
  logic fast_transmitter_pulse_select, tx_on_rx_pair, pulse_on, pulse_neg, pulse_full;
  int n_fail = 0, tests_run = 0, cyc = 0, i, n;

  ldft_regs dut (.ref_clk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .dsp_req, .dsp_sel, .dsp_ack, .dsp_value, .reflect_test_on,
    .powerup_force, .fast_transmitter_pulse_select, .tx_on_rx_pair, .tdr_fire,
    .tdr_width, .pulse_on, .pulse_neg, .pulse_full);

  // ==========================================
  // clock and hang guard
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ==========================================
  // tasks
  task chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("run %0d fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [4:0] a, input logic [15:0] x);
    @(posedge ref_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask
  // data stand one cycle only, so look just after the taking edge
  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask
  // a repeat trigger during the open poll must not disturb it
  task poll(input logic [15:0] x, input logic [7:0] val);
    wr(5'h15, x | 16'h8000);
    #1 chk({dsp_req, dsp_sel}, {1'b1, x[8]});
    wr(5'h15, (x ^ 16'h01FF) | 16'h8000);
    #1 chk(dsp_sel, x[8]);
    rd(5'h15, {7'h00, ~x[8], res_m});
    repeat ($urandom % 4) @(posedge ref_clk);
    @(posedge ref_clk);
    dsp_ack <= 1;
    dsp_value <= val;
    @(posedge ref_clk);
    dsp_ack <= 0;
    #1 chk(dsp_req, 0);
    res_m = val;
    rd(5'h15, {7'h00, ~x[8], res_m});
  endtask
  task pulse(input logic f, input logic [2:0] wd, input int len);
    @(posedge ref_clk);
    tdr_fire <= 1;
    tdr_width <= wd;
    @(posedge ref_clk);
    tdr_fire <= 0;
    if (f) neg_m = ~neg_m;
    #1 chk({pulse_on, pulse_neg, !f && pulse_full}, {1'b1, f && neg_m, !f && wd > 1});
    n = 0;
    while (pulse_on === 1'b1 && n < 20) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    chk(16'(n), 16'(len));
  endtask

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h415DDD2A));
    repeat (8) @(posedge ref_clk);
    arst_n <= 1;
    rd(5'h15, 16'h0000);
    wr(5'h16, 16'hE000);
    wr(5'h13, 16'h0002);
    rd(5'h13, 16'h0002);
    rd(5'h15, 16'h0000);
    rd(5'h16, 16'h0000);
    $display("reset test done");
    res_m = 0;
    for (i = 0; i < 6; i++) begin
      d = $urandom;
      // first two polls cover both select values for sure
      if (i < 2) d[8] = i[0];
      v = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($urandom);
      poll(d, v);
    end
    $display("poll test done");
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      wr(5'h16, d);
      rd(5'h16, d & 16'hE000);
      chk({reflect_test_on, fast_transmitter_pulse_select, tx_on_rx_pair}, d[15:13]);
      chk(powerup_force, d[15]);
    end
    $display("control test done");
    wr(5'h16, 16'hC000);
    neg_m = 1;
    for (i = 1; i < 8; i++) pulse(1, 3'(i), (i * 8 + 9) / 10);
    wr(5'h16, 16'h8000);
    pulse(0, 3'h1, 5);
    pulse(0, 3'h2, 10);
    pulse(0, 3'h7, 10);
    // width zero sends nothing even with the test enabled
    @(posedge ref_clk);
    tdr_fire <= 1;
    tdr_width <= 3'h0;
    @(posedge ref_clk);
    tdr_fire <= 0;
    #1 chk(pulse_on, 0);
    wr(5'h16, 16'h0000);
    @(posedge ref_clk);
    tdr_fire <= 1;
    tdr_width <= 3'h3;
    @(posedge ref_clk);
    tdr_fire <= 0;
    #1 chk(pulse_on, 0);
    $display("pulse test done");
    rd(5'h1F, 16'h0000);
    wr(5'h13, 16'h0001);
    rd(5'h15, 16'h0000);
    wr(5'h13, 16'h0002);
    @(posedge ref_clk);
    clk_en <= 0;
    wr(5'h16, 16'hE000);
    @(posedge ref_clk);
    clk_en <= 1;
    rd(5'h16, 16'h0000);
    $display("refusal test done");
    wrap_up();
  end
endmodule

bind ldft_regs ldft_regs_assertions chk_i (.ref_clk, .arst_n, .clk_en, .reg_addr, .reg_rd,
  .reg_rdata, .dsp_req, .dsp_sel, .dsp_ack, .reflect_test_on, .powerup_force,
  .fast_transmitter_pulse_select, .tdr_fire, .tdr_width, .pulse_on, .pulse_full);
